// ==== design/ppgd_gate_drive.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - gate rate is oscillator rate divided by two.
// - two complementary gates take turns switching the transistors.
// - dead-time separates one gate's high pulse from the other's.
// - both gates low for a while before either goes high.
// - internal oscillator is 160 kHz or 420 kHz by variant.
// - external clock may replace the internal oscillator for sync.
// - soft start ramps drive up gradually after enable.
module ppgd_gate_drive
  import ppgd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic variant_b_i,
  input wire logic ext_sel_i,
  input wire logic ext_clk_i,
  output logic gate_a_o,
  output logic gate_b_o,
  output logic soft_start_done_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] phase_cycles(input logic variant_b);
    logic [CNT_W-1:0] cyc;
    cyc = variant_b ? CNT_W'(2 * OSC_B_HALF) : CNT_W'(2 * OSC_A_HALF);
    return cyc;
  endfunction
  // the level's share of a phase, never zero so each step still switches
  function automatic logic [CNT_W+SS_W-1:0] ramp_on_time(
    input logic [CNT_W-1:0] half,
    input logic [SS_W-1:0] level
  );
    logic [CNT_W+SS_W-1:0] prod;
    prod = {5'h00, half} * ({8'h00, level} + 13'h0001);
    return prod / (CNT_W+SS_W)'(SS_STEPS);
  endfunction
  // ---------------------------------------------------------------
  // enable sync and oscillator
  // ---------------------------------------------------------------
  logic [2:0] en_sync_r;
  logic en_r;
  wire logic en_agree;
  ppgd_if osc_bus ();
  assign en_agree = (en_sync_r[1] == en_sync_r[2]);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_sync_r <= 3'h0;
      en_r <= 1'b0;
    end else begin
      en_sync_r <= {en_sync_r[1:0], enable_i};
      if (en_agree) en_r <= en_sync_r[2];
    end
  end
  assign osc_bus.en = en_r;
  ppgd_osc u_osc (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .variant_b_i(variant_b_i),
    .ext_sel_i(ext_sel_i),
    .ext_clk_i(ext_clk_i),
    .osc(osc_bus)
  );
  // ---------------------------------------------------------------
  // divide by two
  // ---------------------------------------------------------------
  logic phase_r;
  logic phase_nxt;
  logic tick_seen_r;
  logic tick_seen_nxt;
  wire logic phase_edge;
  // two ticks per period
  // phase_r flips every oscillator period, so each gate spans two
  assign phase_edge = osc_bus.osc_tick && tick_seen_r;
  // disable parks the divider so a restart always begins with gate a
  assign tick_seen_nxt = !en_r ? 1'b0 : (tick_seen_r ^ osc_bus.osc_tick);
  assign phase_nxt = !en_r ? 1'b0 : (phase_r ^ phase_edge);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_seen_r <= 1'b0;
    end else begin
      tick_seen_r <= tick_seen_nxt;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
    end
  end
  // ---------------------------------------------------------------
  // soft start
  // ---------------------------------------------------------------
  logic [SS_W-1:0] ss_level_r;
  logic [SS_W-1:0] ss_level_nxt;
  logic [CNT_W-1:0] ss_per_r;
  logic [CNT_W-1:0] ss_per_nxt;
  wire logic ss_done;
  wire logic ss_count;
  wire logic ss_step_end;
  assign ss_done = (ss_level_r == SS_W'(SS_STEPS));
  assign ss_count = phase_edge && !ss_done;
  assign ss_step_end = (ss_per_r == CNT_W'(SS_STEP_PERIODS - 1));
  // widen pulse stepwise
  // the ramp restarts from the narrowest step on every enable
  assign ss_level_nxt = !en_r ? SS_ZERO :
    (ss_count && ss_step_end) ? ss_level_r + 5'h01 : ss_level_r;
  assign ss_per_nxt = (!en_r || (ss_count && ss_step_end)) ? CNT_ZERO :
    ss_count ? ss_per_r + 8'h01 : ss_per_r;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ss_level_r <= SS_ZERO;
    end else begin
      ss_level_r <= ss_level_nxt;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ss_per_r <= CNT_ZERO;
    end else begin
      ss_per_r <= ss_per_nxt;
    end
  end
  // on-time within a phase, in core cycles, grows with the level
  logic [CNT_W+SS_W-1:0] on_cnt_r;
  wire logic [CNT_W+SS_W-1:0] on_limit;
  wire logic [CNT_W-1:0] half_cyc;
  assign half_cyc = phase_cycles(variant_b_i);
  // limitation: with the external clock the ramp assumes the variant rate
  assign on_limit = ss_done ? {(CNT_W+SS_W){1'b1}} : ramp_on_time(half_cyc, ss_level_r);
  // ---------------------------------------------------------------
  // break before make
  // ---------------------------------------------------------------
  typedef enum {ST_OFF, ST_DEAD, ST_DRIVE} ppgd_state_t;
  ppgd_state_t state_r;
  ppgd_state_t state_nxt;
  logic [CNT_W-1:0] dead_r;
  logic side_r;
  wire logic dead_over;
  assign dead_over = (dead_r >= CNT_W'(DEAD_CYC - 1));
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (en_r) state_nxt = ST_DEAD;
      end
      ST_DEAD: begin
        if (!en_r) state_nxt = ST_OFF;
        else if (dead_over) state_nxt = ST_DRIVE;
      end
      ST_DRIVE: begin
        if (!en_r) state_nxt = ST_OFF;
        else if (phase_r != side_r) state_nxt = ST_DEAD;
      end
      default: state_nxt = ST_OFF;
    endcase
  end
  logic [CNT_W-1:0] dead_nxt;
  logic side_nxt;
  logic [CNT_W+SS_W-1:0] on_cnt_nxt;
  assign dead_nxt = (state_r == ST_DEAD) ? dead_r + 8'h01 : CNT_ZERO;
  assign side_nxt = (state_r == ST_DEAD) ? phase_r : side_r;
  assign on_cnt_nxt = (state_r == ST_DRIVE) ? on_cnt_r + 13'h0001 : 13'h0000;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dead_r <= CNT_ZERO;
    end else begin
      dead_r <= dead_nxt;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      side_r <= 1'b0;
    end else begin
      side_r <= side_nxt;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_cnt_r <= 13'h0000;
    end else begin
      on_cnt_r <= on_cnt_nxt;
    end
  end
  // ---------------------------------------------------------------
  // gate outputs
  // ---------------------------------------------------------------
  wire logic drive_on;
  assign drive_on = (state_r == ST_DRIVE) && (state_nxt == ST_DRIVE) && (on_cnt_r < on_limit);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_a_o <= 1'b0;
    end else begin
      gate_a_o <= drive_on && !side_r;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_b_o <= 1'b0;
    end else begin
      gate_b_o <= drive_on && side_r;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      soft_start_done_o <= 1'b0;
    end else begin
      soft_start_done_o <= ss_done;
    end
  end
endmodule // ppgd_gate_drive
`default_nettype wire

// ==== design/ppgd_pkg.sv ====
package ppgd_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CORE_CLK_HZ = 40000000;
  localparam int OSC_A_HZ = 160000;
  localparam int OSC_B_HZ = 420000;
  // oscillator half period in core cycles, rounded down
  localparam int OSC_A_HALF = CORE_CLK_HZ / (2 * OSC_A_HZ);
  localparam int OSC_B_HALF = CORE_CLK_HZ / (2 * OSC_B_HZ);
  localparam int DEAD_NS = 100;
  localparam int CLK_PERIOD_NS = 25;
  // least time: round up
  localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_STEPS = 16;
  localparam int SS_STEP_PERIODS = 8;
  localparam int CNT_W = 8;
  localparam int SS_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [SS_W-1:0] SS_ZERO = 5'h00;
endpackage : ppgd_pkg

// ==== design/ppgd_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ppgd_if;
  logic osc_tick;
  logic en;
  modport src (output osc_tick, input en);
  modport snk (input osc_tick, output en);
endinterface : ppgd_if
`default_nettype wire

// ==== design/ppgd_osc.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppgd_osc
  import ppgd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic variant_b_i,
  input wire logic ext_sel_i,
  input wire logic ext_clk_i,
  ppgd_if.src osc
);
  // ---------------------------------------------------------------
  // internal oscillator
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic int_tick;
  wire logic [CNT_W-1:0] half_top;
  assign half_top = variant_b_i ? CNT_W'(OSC_B_HALF - 1) : CNT_W'(OSC_A_HALF - 1);
  assign int_tick = osc.en && (cnt_r >= half_top);
  assign cnt_nxt = (!osc.en || int_tick) ? CNT_ZERO : cnt_r + 8'h01;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_r <= CNT_ZERO;
    else cnt_r <= cnt_nxt;
  end
  // ---------------------------------------------------------------
  // external sync clock
  // ---------------------------------------------------------------
  logic [2:0] ext_sync_r;
  logic ext_lvl_r;
  wire logic ext_agree;
  wire logic ext_tick;
  // a change counts once stages two and three agree
  assign ext_agree = (ext_sync_r[1] == ext_sync_r[2]);
  assign ext_tick = ext_agree && (ext_sync_r[2] != ext_lvl_r);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_sync_r <= 3'h0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clk_i};
      if (ext_agree) ext_lvl_r <= ext_sync_r[2];
    end
  end
  // external clock replaces oscillator
  // every external edge is one half period, like an internal tick
  assign osc.osc_tick = ext_sel_i ? (osc.en && ext_tick) : int_tick;
endmodule // ppgd_osc
`default_nettype wire

// ==== dv/ppgd_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppgd_switch_model (
  input wire logic core_clk_i,
  input wire logic gate_a_i,
  input wire logic gate_b_i,
  output logic [15:0] short_cnt_o,
  output logic [15:0] b_cnt_o
);
  logic b_d = 1'b0;
  initial begin
    short_cnt_o = 16'h0000;
    b_cnt_o = 16'h0000;
  end
  // ------
  // switches
  // ------
  // both on shorts the primary; counted, not fatal, so the bench can judge
  always @(posedge core_clk_i) begin
    b_d <= gate_b_i;
    if (gate_a_i && gate_b_i) short_cnt_o <= short_cnt_o + 16'h0001;
    if (gate_b_i && !b_d) b_cnt_o <= b_cnt_o + 16'h0001;
  end
endmodule // ppgd_switch_model
`default_nettype wire

// ==== dv/ppgd_gate_drive_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppgd_gate_drive_monitor (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic variant_b_i,
  input wire logic ext_sel_i,
  input wire logic gate_a_o,
  input wire logic gate_b_o,
  input wire logic soft_start_done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ------
  // gate checks
  // ------
  a_never_both: assert property (!(gate_a_o && gate_b_o)) else $error("both gates high");
  a_dead_ab: assert property ($fell(gate_a_o) |-> !gate_b_o [*4]) else $error("short gap a-b");
  a_dead_ba: assert property ($fell(gate_b_o) |-> !gate_a_o [*4]) else $error("short gap b-a");
  a_low_before_a: assert property ($rose(gate_a_o) |-> $past(!gate_b_o, 4))
    else $error("a rose too soon");
  a_low_before_b: assert property ($rose(gate_b_o) |-> $past(!gate_a_o, 4))
    else $error("b rose too soon");
  a_idle_low: assert property (!enable_i [*8] |-> !gate_a_o && !gate_b_o && !soft_start_done_o)
    else $error("active while disabled");
  a_period_fast: assert property ($rose(gate_a_o) && soft_start_done_o && variant_b_i && !ext_sel_i
    |-> ##188 ($rose(gate_a_o) || !soft_start_done_o)) else $error("bad gate period");
  a_width_slow: assert property ($rose(gate_a_o) && !variant_b_i && !ext_sel_i
    |-> ##[1:246] !gate_a_o) else $error("pulse too long");
  a_soft_hold: assert property ($rose(enable_i) |-> !soft_start_done_o [*8])
    else $error("ramp skipped");
endmodule // ppgd_gate_drive_monitor
bind ppgd_gate_drive ppgd_gate_drive_monitor ppgd_gate_drive_monitor_i (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .enable_i(enable_i), .variant_b_i(variant_b_i), .ext_sel_i(ext_sel_i),
  .gate_a_o(gate_a_o), .gate_b_o(gate_b_o), .soft_start_done_o(soft_start_done_o));
`default_nettype wire

// ==== dv/push_pull_gate_drive_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module push_pull_gate_drive_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic enable_i = 1'b0;
  logic variant_b_i = 1'b0;
  logic ext_sel_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic ext_run = 1'b0;
  logic gate_a, gate_b, ss_done;
  logic [15:0] short_cnt, b_cnt;
  int error_cnt = 0;
  int total_checks = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  // common sync clock
  // sync clock half period of 60 cycles, moved on falling edges
  always #1500 if (ext_run) ext_clk_i = ~ext_clk_i;
  ppgd_gate_drive ppgd_gate_drive_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .enable_i(enable_i), .variant_b_i(variant_b_i), .ext_sel_i(ext_sel_i), .ext_clk_i(ext_clk_i),
    .gate_a_o(gate_a), .gate_b_o(gate_b), .soft_start_done_o(ss_done));
  ppgd_switch_model ppgd_switch_model_i (.core_clk_i(core_clk_i), .gate_a_i(gate_a),
    .gate_b_i(gate_b), .short_cnt_o(short_cnt), .b_cnt_o(b_cnt));
  // ------
  // helpers
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic start(input logic v, input logic x);
    @(negedge core_clk_i);
    rst_b_i = 1'b0;
    enable_i = 1'b0;
    variant_b_i = v;
    ext_sel_i = x;
    ext_run = x;
    repeat (20) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    enable_i = 1'b1;
  endtask
  // cycles to the next rise of gate a; a hang shows up as 600
  task automatic next_a(output int n);
    n = 0;
    while (gate_a === 1'b1 && n < 600) begin @(negedge core_clk_i); n++; end
    while (gate_a !== 1'b1 && n < 600) begin @(negedge core_clk_i); n++; end
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_rate(input logic v, input logic x, input logic [15:0] per);
    int n;
    logic [15:0] b0;
    start(v, x);
    next_a(n);
    next_a(n);
    b0 = b_cnt;
    next_a(n);
    chk(16'(n), per);
    chk(b_cnt - b0, 16'h0001);
    chk(short_cnt, 16'h0000);
  endtask
  task automatic t_soft();
    int n, w0, w1;
    start(1'b1, 1'b0);
    next_a(n);
    for (w0 = 0; gate_a === 1'b1 && w0 < 600; w0++) @(negedge core_clk_i);
    repeat (30000) if (ss_done !== 1'b1) @(negedge core_clk_i);
    chk({15'h0000, ss_done}, 16'h0001);
    next_a(n);
    for (w1 = 0; gate_a === 1'b1 && w1 < 600; w1++) @(negedge core_clk_i);
    chk(16'(w0 < w1), 16'h0001);
  endtask
  task automatic t_off();
    int n;
    logic seen;
    seen = 1'b0;
    enable_i = 1'b0;
    repeat (10) @(negedge core_clk_i);
    repeat (300) begin @(negedge core_clk_i); seen = seen | gate_a | gate_b; end
    chk({14'h0000, seen, ss_done}, 16'h0000);
    enable_i = 1'b1;
    next_a(n);
    chk(16'(n >= 8 && n < 600), 16'h0001);
  endtask
  initial begin
    t_rate(1'b0, 1'b0, 16'h01F4);
    t_rate(1'b1, 1'b0, 16'h00BC);
    t_rate(1'b0, 1'b1, 16'h00F0);
    t_soft();
    t_off();
    end_of_test();
  end
  // about 15k cycles expected; cut off at 60k
  initial begin
    #1500000;
    error_cnt++;
    end_of_test();
  end
endmodule // push_pull_gate_drive_tb_top
`default_nettype wire
